// >>> afic_defines.vh
// Purpose: register map and field constants for the autofocus IIR config block
// Assumes: AHB-Lite word access, 32-bit data
// Notes: offsets are byte addresses
// Functional notes
// RQ1: clear IIR shift registers on the pixel after position equals start column.
// RQ2: software programs the filter start column with even values only.
// RQ3: lowest six bits of the stats buffer address are ignored.
// RQ4: buffer address writes accepted while busy, applied from next frame.
// RQ5: reads of the buffer address return the latest written value.
// RQ6: coefficients are 12-bit signed, six fractional bits, -32 to 31+63/64.
// RQ7: even coefficient in bits 11-0, odd in 27-16, others read zero.
// RQ8: set-0 coefficients paired 0/1, 2/3, 4/5, 6/7, 8/9 in consecutive registers.
// RQ9: software sets paxel horizontal start at least start column plus one.
// RQ10: coefficient ten sits alone in bits 11-0 of its own register.
// RQ11: a second independent coefficient set uses the same packing and format.
// RQ12: active buffer address is captured at each frame start.
`ifndef AFIC_DEFINES_VH
`define AFIC_DEFINES_VH
`define AFIC_OFS_START_COL 8'h00
`define AFIC_OFS_BUF_ADDR 8'h04
`define AFIC_OFS_SET0_BASE 8'h08
`define AFIC_OFS_SET1_BASE 8'h20
`define AFIC_OFS_ENGINE 8'h38
`define AFIC_NUM_PAIR_REGS 6
`define AFIC_COEF_W 12
`define AFIC_COEF_FRAC 6
`define AFIC_EVEN_LSB 0
`define AFIC_ODD_LSB 16
`define AFIC_BUF_ALIGN_BITS 6
`define AFIC_RST_WORD 32'h00000000
`endif

// >>> afic_coef_bank.v
// Purpose: one set of eleven IIR coefficients held as six packed registers
// Assumes: word write strobe and index from the bus slave
// Notes: last register holds coefficient ten alone
`timescale 1ns/100ps
`default_nettype none
`include "afic_defines.vh"
module afic_coef_bank (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // write side
  input wire wr_en,
  input wire [2:0] wr_idx,
  input wire [31:0] wr_data,
  // read side
  input wire [2:0] rd_idx,
  output reg [31:0] rd_data,
  // coefficients flattened, coefficient k at bits 12k+11..12k
  output wire [131:0] coefs
);
  reg [11:0] even_r [0:5];
  reg [11:0] odd_r [0:5];
  genvar g;
  generate
    for (g = 0; g < `AFIC_NUM_PAIR_REGS; g = g + 1) begin : g_pair
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          even_r[g] <= 12'h000;
          odd_r[g] <= 12'h000;
        end else if (wr_en && wr_idx == g) begin
          even_r[g] <= wr_data[`AFIC_EVEN_LSB+11:`AFIC_EVEN_LSB]; // RQ7
          if (g != 5) begin
            odd_r[g] <= wr_data[`AFIC_ODD_LSB+11:`AFIC_ODD_LSB]; // RQ8
          end
        end
      end
      assign coefs[24*g+11:24*g] = even_r[g];
      if (g != 5) begin : g_odd
        assign coefs[24*g+23:24*g+12] = odd_r[g];
      end
    end
  endgenerate
  always @* begin
    rd_data = 32'h00000000;
    if (rd_idx < 3'h5) begin
      rd_data = {4'h0, odd_r[rd_idx], 4'h0, even_r[rd_idx]}; // RQ7
    end else if (rd_idx == 3'h5) begin
      rd_data = {20'h00000, even_r[5]}; // RQ10
    end
  end
endmodule
`default_nettype wire

// >>> afic_iir_stage.v
// Purpose: second-order IIR section applied to the pixel stream
// Assumes: coefficients signed Q5.6, pixel 10-bit unsigned
// Notes: state cleared on the pixel after the start column
`timescale 1ns/100ps
`default_nettype none
`include "afic_defines.vh"
module afic_iir_stage (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // pixel stream
  input wire pix_valid,
  input wire [9:0] pix_data,
  input wire clear,
  // coefficients: gain, a1, a2, b0, b1, b2
  input wire [71:0] coefs,
  // result
  output reg [15:0] out_r
);
  reg signed [15:0] w1_r;
  reg signed [15:0] w2_r;
  wire signed [11:0] c_gain = coefs[11:0]; // RQ6
  wire signed [11:0] c_a1 = coefs[23:12];
  wire signed [11:0] c_a2 = coefs[35:24];
  wire signed [11:0] c_b0 = coefs[47:36];
  wire signed [11:0] c_b1 = coefs[59:48];
  wire signed [11:0] c_b2 = coefs[71:60];
  wire signed [16:0] x_s = {7'h00, pix_data};
  wire signed [29:0] xg = x_s * c_gain;
  wire signed [29:0] fb = w1_r * c_a1 + w2_r * c_a2;
  wire signed [29:0] w0_full = xg + fb;
  wire signed [15:0] w0 = w0_full[`AFIC_COEF_FRAC+15:`AFIC_COEF_FRAC];
  wire signed [29:0] y_full = w0 * c_b0 + w1_r * c_b1 + w2_r * c_b2;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w1_r <= 16'h0000;
      w2_r <= 16'h0000;
      out_r <= 16'h0000;
    end else if (pix_valid) begin
      if (clear) begin
        w1_r <= 16'h0000; // RQ1
        w2_r <= 16'h0000;
        out_r <= 16'h0000;
      end else begin
        w1_r <= w0;
        w2_r <= w1_r;
        out_r <= y_full[`AFIC_COEF_FRAC+15:`AFIC_COEF_FRAC];
      end
    end
  end
endmodule
`default_nettype wire

// >>> afic_top.v
// Purpose: autofocus IIR configuration registers and filter datapath
// Assumes: AHB-Lite slave, pixel inputs from the capture controller on CLK
// Notes: zero wait states, response always OKAY
//
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "afic_defines.vh"
module afic_top (
  // clock and reset
  input wire CLK,
  input wire RST_N,
  // ahb-lite slave
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output wire [31:0] HRDATA,
  output wire HREADYOUT,
  output wire HRESP,
  // pixel stream
  input wire PIX_VALID,
  input wire [9:0] PIX_DATA,
  input wire LINE_START,
  input wire FRAME_START,
  // results
  output wire [15:0] FILT0_OUT,
  output wire [15:0] FILT1_OUT,
  output wire [31:0] ACTIVE_BUF_ADDR,
  output wire [11:0] H_POS
);
  reg rst_s1_r;
  reg rst_s2_r;
  wire rst_n = rst_s2_r;
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // address phase capture
  reg wr_pend_r;
  reg rd_pend_r;
  reg [7:0] addr_r;
  wire take = HSEL && HREADY && HTRANS[1];
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end else begin
      wr_pend_r <= take && HWRITE;
      rd_pend_r <= take && !HWRITE;
      if (take) begin
        addr_r <= HADDR[7:0];
      end
    end
  end
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // decode
  wire in_set0 = addr_r >= `AFIC_OFS_SET0_BASE && addr_r < `AFIC_OFS_SET1_BASE;
  wire in_set1 = addr_r >= `AFIC_OFS_SET1_BASE && addr_r < `AFIC_OFS_ENGINE;
  wire [7:0] off0 = addr_r - `AFIC_OFS_SET0_BASE;
  wire [7:0] off1 = addr_r - `AFIC_OFS_SET1_BASE;
  wire [2:0] idx0 = off0[4:2];
  wire [2:0] idx1 = off1[4:2];

  // configuration registers
  reg [11:0] start_col_r;
  reg [31:0] buf_addr_r;
  reg [31:0] active_buf_r;
  reg coef_sel_r;
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      start_col_r <= 12'h000;
      buf_addr_r <= `AFIC_RST_WORD;
      coef_sel_r <= 1'b0;
    end else if (wr_pend_r) begin
      if (addr_r == `AFIC_OFS_START_COL) begin
        start_col_r <= HWDATA[11:0]; // RQ1
      end
      if (addr_r == `AFIC_OFS_BUF_ADDR) begin
        buf_addr_r <= HWDATA; // RQ4
      end
      if (addr_r == `AFIC_OFS_ENGINE) begin
        coef_sel_r <= HWDATA[0];
      end
    end
  end

  // frame-start capture of the buffer address
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      active_buf_r <= `AFIC_RST_WORD;
    end else if (FRAME_START) begin
      active_buf_r <= {buf_addr_r[31:`AFIC_BUF_ALIGN_BITS], 6'h00}; // RQ12 RQ3
    end
  end
  assign ACTIVE_BUF_ADDR = active_buf_r;

  // coefficient sets
  wire [31:0] rd0;
  wire [31:0] rd1;
  wire [131:0] c0;
  wire [131:0] c1;
  afic_coef_bank u_set0 (
    .clk(CLK),
    .rst_n(rst_n),
    .wr_en(wr_pend_r && in_set0),
    .wr_idx(idx0),
    .wr_data(HWDATA),
    .rd_idx(idx0),
    .rd_data(rd0),
    .coefs(c0)
  );
  afic_coef_bank u_set1 (
    .clk(CLK),
    .rst_n(rst_n),
    .wr_en(wr_pend_r && in_set1), // RQ11
    .wr_idx(idx1),
    .wr_data(HWDATA),
    .rd_idx(idx1),
    .rd_data(rd1),
    .coefs(c1)
  );

  // read mux
  reg [31:0] rdata;
  always @* begin
    rdata = 32'h00000000;
    if (rd_pend_r) begin
      if (addr_r == `AFIC_OFS_START_COL) begin
        rdata = {20'h00000, start_col_r};
      end else if (addr_r == `AFIC_OFS_BUF_ADDR) begin
        rdata = buf_addr_r; // RQ5
      end else if (in_set0) begin
        rdata = rd0;
      end else if (in_set1) begin
        rdata = rd1;
      end else if (addr_r == `AFIC_OFS_ENGINE) begin
        rdata = {31'h00000000, coef_sel_r};
      end
    end
  end
  assign HRDATA = rdata;

  // horizontal position and clear
  reg [11:0] hpos_r;
  reg clr_pend_r;
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      hpos_r <= 12'h000;
      clr_pend_r <= 1'b0;
    end else if (LINE_START) begin
      hpos_r <= 12'h000;
      clr_pend_r <= 1'b0;
    end else if (PIX_VALID) begin
      hpos_r <= hpos_r + 12'h001;
      clr_pend_r <= (hpos_r == start_col_r); // RQ1
    end
  end
  assign H_POS = hpos_r;

  // two filters, fed by the selected set
  wire [131:0] cs = coef_sel_r ? c1 : c0;
  afic_iir_stage u_f0 (
    .clk(CLK),
    .rst_n(rst_n),
    .pix_valid(PIX_VALID),
    .pix_data(PIX_DATA),
    .clear(clr_pend_r),
    .coefs(cs[71:0]),
    .out_r(FILT0_OUT)
  );
  afic_iir_stage u_f1 (
    .clk(CLK),
    .rst_n(rst_n),
    .pix_valid(PIX_VALID),
    .pix_data(PIX_DATA),
    .clear(clr_pend_r),
    .coefs({cs[131:72], cs[11:0]}),
    .out_r(FILT1_OUT)
  );
endmodule
`default_nettype wire

// >>> afic_monitor.sv
// Purpose: port checker for afic_top
// Assumes: zero wait bus slave
// Notes: bound from the testbench
`timescale 1ns/100ps
`default_nettype none
module afic_monitor (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // pixels
  input wire logic PIX_VALID,
  input wire logic LINE_START,
  input wire logic FRAME_START,
  input wire logic [31:0] ACTIVE_BUF_ADDR,
  input wire logic [11:0] H_POS
);
  logic dp_r, cf_r, ten_r;
  wire take = HSEL && HREADY && HTRANS[1];
  wire rd = take && !HWRITE;
  wire cf = rd && HADDR >= 32'h8 && HADDR <= 32'h34;
  wire ten = rd && (HADDR == 32'h1C || HADDR == 32'h34);
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N) {dp_r, cf_r, ten_r} <= 3'h0;
    else {dp_r, cf_r, ten_r} <= {take, cf, ten};
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus not ready or not okay");
  a_buf_align: assert property (ACTIVE_BUF_ADDR[5:0] == 6'h0)
    else $error("buffer address low bits set");
  a_buf_hold: assert property (!FRAME_START |=> $stable(ACTIVE_BUF_ADDR))
    else $error("buffer address moved mid frame");
  a_coef_rsvd: assert property (cf_r |-> !HRDATA[31:28] && !HRDATA[15:12])
    else $error("coefficient reserved bits set");
  a_ten_rsvd: assert property (ten_r |-> HRDATA[31:12] == 20'h0)
    else $error("coefficient ten upper bits set");
  a_rdata_idle: assert property (!dp_r |-> HRDATA == 32'h0)
    else $error("read data outside data phase");
  a_line_zero: assert property (LINE_START |=> H_POS == 12'h0)
    else $error("position not zero after line start");
  a_pos_step: assert property (PIX_VALID && !LINE_START |=>
    H_POS == $past(H_POS) + 12'h1)
    else $error("position did not step");
  a_pos_hold: assert property (!PIX_VALID && !LINE_START |=> $stable(H_POS))
    else $error("position moved without pixel");
endmodule
`default_nettype wire

// >>> afic_pix_src.sv
// Purpose: capture controller pixel source
// Assumes: one line per go pulse
// Notes: slow mode gives a pixel every other cycle
`timescale 1ns/100ps
`default_nettype none
module afic_pix_src (
  // clock and control
  input wire logic clk,
  input wire logic go,
  input wire logic slow,
  input wire logic [11:0] len,
  // pixel stream
  output logic line_start = 1'b0,
  output logic pix_valid = 1'b0,
  output logic [9:0] pix_data = 10'h0,
  output logic busy = 1'b0
);
  logic [11:0] cnt_r = 12'h0;
  logic ph_r = 1'b0;
  always @(posedge clk) begin
    line_start <= go && !busy;
    ph_r <= !ph_r;
    if (busy && (ph_r || !slow)) begin
      pix_valid <= 1'b1;
      pix_data <= {cnt_r[8:0], 1'b1};
      cnt_r <= cnt_r + 12'h1;
      busy <= cnt_r != len - 12'h1;
    end else begin
      // idle data keeps changing so stale values never look valid
      pix_valid <= 1'b0;
      pix_data <= ~pix_data;
      if (go && !busy) begin
        busy <= 1'b1;
        cnt_r <= 12'h0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> afic_tb.sv
// Purpose: self-checking bench for afic_top
// Assumes: zero wait bus, pixel source model
// Notes: registers checked through the bus
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0, frame = 1'b0, go = 1'b0, slow = 1'b0;
  wire logic [31:0] hrdata, abuf;
  wire logic [15:0] f0, f1;
  wire logic [11:0] hpos;
  wire logic [9:0] pd;
  wire logic hready, hresp, pv, ls, busy;
  int n_errors = 0, checked = 0;
  always #25 CLK = ~CLK;
  afic_top afic_top_i (.CLK(CLK), .RST_N(RST_N), .HSEL(1'b1),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .PIX_VALID(pv), .PIX_DATA(pd),
    .LINE_START(ls), .FRAME_START(frame), .FILT0_OUT(f0),
    .FILT1_OUT(f1), .ACTIVE_BUF_ADDR(abuf), .H_POS(hpos));
  afic_pix_src afic_pix_src_i (.clk(CLK), .go(go), .slow(slow),
    .len(12'h014), .line_start(ls), .pix_valid(pv), .pix_data(pd),
    .busy(busy));
  task close_out;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task bus(input logic w, input logic [31:0] a, d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge CLK); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge CLK); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task wt(input logic [11:0] p);
    int n;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (hpos !== p && n < 200);
    chk("hpos", {20'h0, hpos}, {20'h0, p});
  endtask
  task t_reset;
    for (int i = 0; i < 17; i++) begin
      bus(1'b0, 32'(i * 4), 32'h0);
      chk("reset", rd, 32'h0);
    end
  endtask
  task t_coef;
    logic [11:0] k;
    for (int i = 0; i < 12; i++) begin
      k = 12'(i);
      bus(1'b1, 32'(8 + i * 4), {4'hF, 12'h7FF - k, 4'hF, 12'h800 + k});
    end
    for (int i = 0; i < 12; i++) begin
      k = 12'(i);
      bus(1'b0, 32'(8 + i * 4), 32'h0);
      chk("coef", rd, (i % 6 == 5) ? {20'h0, 12'h800 + k} :
        {4'h0, 12'h7FF - k, 4'h0, 12'h800 + k});
    end
    bus(1'b1, 32'h40, 32'hFFFFFFFF);
    bus(1'b0, 32'h40, 32'h0);
    chk("unmapped", rd, 32'h0);
  endtask
  task fp;
    frame <= 1'b1;
    @(posedge CLK);
    frame <= 1'b0;
    @(posedge CLK);
  endtask
  task t_buf;
    bus(1'b1, 32'h4, 32'h1234567F);
    bus(1'b0, 32'h4, 32'h0);
    chk("buf rd", rd, 32'h1234567F);
    chk("buf old", abuf, 32'h0);
    fp();
    chk("buf new", abuf, 32'h12345640);
    bus(1'b1, 32'h4, 32'hCAFE0000);
    chk("buf hold", abuf, 32'h12345640);
    bus(1'b0, 32'h4, 32'h0);
    chk("buf latest", rd, 32'hCAFE0000);
    chk("buf wait", abuf, 32'h12345640);
    fp();
    chk("buf next", abuf, 32'hCAFE0000);
  endtask
  task t_clear;
    bus(1'b1, 32'h0, 32'hFFFFF00A);
    bus(1'b0, 32'h0, 32'h0);
    chk("start col", rd, 32'h0000000A);
    slow <= 1'b1;
    go <= 1'b1;
    @(posedge CLK);
    go <= 1'b0;
    // pixel 0xB is the cleared one, seen once position reads 0xC
    wt(12'h00C);
    chk("filt0", {16'h0, f0}, 32'h0);
    chk("filt1", {16'h0, f1}, 32'h0);
    // first output from cleared state, set 0, pixel value 25
    wt(12'h00D);
    chk("filt0 first", {16'h0, f0}, 32'h00009C19);
    chk("filt1 first", {16'h0, f1}, 32'h000063CE);
    wt(12'h014);
    bus(1'b1, 32'h38, 32'h00000001);
    bus(1'b0, 32'h38, 32'h0);
    chk("set sel", rd, 32'h00000001);
    slow <= 1'b0;
    go <= 1'b1;
    @(posedge CLK);
    go <= 1'b0;
    // position still shows the last line until the new one starts
    wt(12'h000);
    wt(12'h00C);
    chk("filt0 fast", {16'h0, f0}, 32'h0);
    chk("filt1 fast", {16'h0, f1}, 32'h0);
    // first output from cleared state, set 1, pixel value 25
    wt(12'h00D);
    chk("filt0 set1", {16'h0, f0}, 32'h00009CA3);
    chk("filt1 set1", {16'h0, f1}, 32'h00006343);
    wt(12'h014);
  endtask
  initial begin
    #1000000;
    n_errors++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    t_reset();
    t_coef();
    t_buf();
    t_clear();
    close_out();
  end
endmodule
bind afic_top afic_monitor afic_monitor_i (.CLK(CLK), .RST_N(RST_N),
  .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .PIX_VALID(PIX_VALID), .LINE_START(LINE_START),
  .FRAME_START(FRAME_START), .ACTIVE_BUF_ADDR(ACTIVE_BUF_ADDR),
  .H_POS(H_POS));
`default_nettype wire
